// file: logic/periph_dma_ptr_counter_regs.sv
// Pointer and counter register set of a peripheral DMA channel pair,
// with the transfer engine that moves data between peripheral and memory.
// Assumes the peripheral and the memory port run on ref_clk_i; channel
// enables come from the transfer control logic outside this block.
// Software keeps the following descriptor valid before the current count
// runs out; the reload happens on the same edge that takes the count to zero.
// Transfer unit codes other than byte and half-word move a word.
//
// Functional notes
// - A zero current receive count stops receive; nonzero starts it when enabled.
// - A zero current transmit count stops transmit; nonzero starts it when enabled, in half duplex only while receive is disabled.
// - The receive following pointer is a read-write register.
// - The receive following count is a read-write register.
// - The transmit following pointer is a read-write register.
// - The transmit following count is a read-write register.
// - Half duplex shares one current pointer for both directions.
// - Half duplex shares one current count for both directions.
// - Half duplex shares one following pointer for both directions.
// - Half duplex shares one following count for both directions.
// - At zero count, a nonzero following buffer is chained in and cleared.
// - Each transfer advances the pointer by 1, 2 or 4 and decrements count.
// - End flag on count reaching zero; full or empty flag when both are zero.
// - Writing a nonzero count of a direction clears its end flag.
`timescale 1ns/1ps
`include "periph_dma_params.svh"

module periph_dma_ptr_counter_regs #(
	parameter bit HALF_DUPLEX = 1'b0
) (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// Register port.
	input wire logic [11:0] addr_i,
	input wire logic [31:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rd_data_o,
	// Channel enables and transfer unit from the peripheral.
	input wire logic rx_enable_i,
	input wire logic tx_enable_i,
	input wire logic [1:0] unit_i,
	// Peripheral receive side.
	input wire logic rx_ready_i,
	input wire logic [31:0] rx_data_i,
	output logic rx_take_o,
	// Peripheral transmit side.
	input wire logic tx_ready_i,
	output logic tx_write_o,
	output logic [31:0] tx_data_o,
	// Memory port.
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [31:0] mem_addr_o,
	output logic [31:0] mem_wdata_o,
	output logic [1:0] mem_size_o,
	input wire logic mem_gnt_i,
	input wire logic mem_rvalid_i,
	input wire logic [31:0] mem_rdata_i,
	// Status flags towards the peripheral status register.
	output logic rx_end_flag_o,
	output logic rx_buffers_full_flag_o,
	output logic tx_end_flag_o,
	output logic tx_buffers_empty_flag_o
);

	// Half duplex folds the transmit descriptor onto the receive one.
	// Channel one then keeps its reset value and is never read.
	localparam int TXI = HALF_DUPLEX ? 0 : 1;

	// Whole state of the block.
	// One record keeps reset and the register copy in a single place.
	typedef struct packed {
		periph_dma_pkg::chan_t [1:0] ch;
		logic rx_end;
		logic rx_full;
		logic tx_end;
		logic tx_empty;
		periph_dma_pkg::state_t st;
		logic [1:0] unit;
		logic [31:0] data;
		logic [31:0] rdata;
	} state_reg_t;

	state_reg_t s_r;
	state_reg_t s_nxt;

	// Per-channel step results.
	// Index 0 is receive and index 1 transmit; half duplex uses only 0.
	periph_dma_pkg::chan_t step_out[2];
	logic reached[2];
	logic both[2];
	logic [3:0] ch_sel[2];
	logic ch_step[2];

	// Decoded strobes, completions and start conditions.
	logic [7:0] hit;
	logic [3:0] rx_sel;
	logic [3:0] tx_sel;
	logic rx_step;
	logic tx_step;
	logic rx_go;
	logic tx_go;
	logic wr_nonzero;

	// One-hot decode of the eight descriptor registers, in table order.
	// Unmapped offsets give no hit, so such writes fall away silently.
	function automatic logic [7:0] decode_slot(input logic [11:0] a);
		case (a)
			`OFF_RX_PTR: decode_slot = 8'h01;
			`OFF_RX_CNT: decode_slot = 8'h02;
			`OFF_TX_PTR: decode_slot = 8'h04;
			`OFF_TX_CNT: decode_slot = 8'h08;
			`OFF_RX_NPTR: decode_slot = 8'h10;
			`OFF_RX_NCNT: decode_slot = 8'h20;
			`OFF_TX_NPTR: decode_slot = 8'h40;
			`OFF_TX_NCNT: decode_slot = 8'h80;
			default: decode_slot = 8'h00;
		endcase
	endfunction

	// Widens a counter to the data bus with zero upper bits.
	function automatic logic [31:0] cnt_word(input logic [`CNT_W-1:0] c);
		cnt_word = {16'h0000, c};
	endfunction

	// Write decode, grouped per direction as ptr, cnt, nptr, ncnt.
	// The nonzero test looks only at the implemented counter bits.
	always_comb begin
		hit = wr_i ? decode_slot(addr_i) : 8'h00;
		rx_sel = {hit[5], hit[4], hit[1], hit[0]};
		tx_sel = {hit[7], hit[6], hit[3], hit[2]};
		wr_nonzero = (wr_data_i[`CNT_W-1:0] != `CNT_RST);
	end

	// Descriptor routing; in half duplex both directions hit channel zero.
	// Sharing the storage, rather than mirroring it, keeps both views
	// equal by construction, with no window in which they could differ.
	always_comb begin
		if (HALF_DUPLEX) begin
			ch_sel[0] = rx_sel | tx_sel;
			ch_sel[1] = 4'h0;
			ch_step[0] = rx_step | tx_step;
			ch_step[1] = 1'b0;
		end else begin
			ch_sel[0] = rx_sel;
			ch_sel[1] = tx_sel;
			ch_step[0] = rx_step;
			ch_step[1] = tx_step;
		end
	end

	// Next-value logic of both descriptors.
	// The step module never sees the engine state; completion is its cue.
	for (genvar k = 0; k < 2; k++) begin : g_chan
		dma_channel_step u_step (
			.cur_i(s_r.ch[k]),
			.unit_i(s_r.unit),
			.step_i(ch_step[k]),
			.wr_sel_i(ch_sel[k]),
			.wdata_i(wr_data_i),
			.nxt_o(step_out[k]),
			.reached_zero_o(reached[k]),
			.both_zero_o(both[k])
		);
	end

	// Start conditions; receive wins so a peripheral overrun is less likely.
	// In half duplex an enabled receiver blocks transmit, so the shared
	// descriptor is never stepped by both directions in one cycle.
	always_comb begin
		rx_go = rx_enable_i && rx_ready_i &&
			(s_r.ch[0].cnt != `CNT_RST);
		tx_go = tx_enable_i && tx_ready_i &&
			(s_r.ch[TXI].cnt != `CNT_RST) &&
			!(HALF_DUPLEX && rx_enable_i);
	end

	// Transfer completions.
	// A receive step is the granted write; a transmit step is the holding
	// register write, so the count drops only once data is delivered.
	always_comb begin
		rx_step = (s_r.st == periph_dma_pkg::ST_RX_WR) && mem_gnt_i;
		tx_step = (s_r.st == periph_dma_pkg::ST_TX_PUT);
	end

	// Engine, flags and read data.
	// The descriptors always take the step results; the rest holds.
	always_comb begin
		s_nxt = s_r;
		s_nxt.ch[0] = step_out[0];
		s_nxt.ch[1] = step_out[1];

		// Flag clears first, so a set in the same cycle wins.
		// Full and empty go with the end flag of the same direction.
		if ((hit[1] || hit[5]) && wr_nonzero) begin
			s_nxt.rx_end = 1'b0;
			s_nxt.rx_full = 1'b0;
		end
		if ((hit[3] || hit[7]) && wr_nonzero) begin
			s_nxt.tx_end = 1'b0;
			s_nxt.tx_empty = 1'b0;
		end
		if (rx_step && reached[0]) begin
			s_nxt.rx_end = 1'b1;
		end
		if (rx_step && both[0]) begin
			s_nxt.rx_full = 1'b1;
		end
		if (tx_step && reached[TXI]) begin
			s_nxt.tx_end = 1'b1;
		end
		if (tx_step && both[TXI]) begin
			s_nxt.tx_empty = 1'b1;
		end

		// Transfer sequencing.
		// Only one transfer is in flight, so one data register serves
		// both directions at the cost of some throughput.
		case (s_r.st)
			periph_dma_pkg::ST_IDLE: begin
				if (rx_go) begin
					s_nxt.data = rx_data_i;
					s_nxt.unit = unit_i;
					s_nxt.st = periph_dma_pkg::ST_RX_WR;
				end else if (tx_go) begin
					s_nxt.unit = unit_i;
					s_nxt.st = periph_dma_pkg::ST_TX_RD;
				end
			end
			periph_dma_pkg::ST_RX_WR: begin
				if (mem_gnt_i) begin
					s_nxt.st = periph_dma_pkg::ST_IDLE;
				end
			end
			periph_dma_pkg::ST_TX_RD: begin
				if (mem_gnt_i) begin
					s_nxt.st = periph_dma_pkg::ST_TX_WAIT;
				end
			end
			periph_dma_pkg::ST_TX_WAIT: begin
				if (mem_rvalid_i) begin
					s_nxt.data = mem_rdata_i;
					s_nxt.st = periph_dma_pkg::ST_TX_PUT;
				end
			end
			periph_dma_pkg::ST_TX_PUT: begin
				s_nxt.st = periph_dma_pkg::ST_IDLE;
			end
			default: begin
				s_nxt.st = periph_dma_pkg::ST_IDLE;
			end
		endcase

		// Read data stands only in the cycle after the strobe.
		// Zero outside that cycle lets several slaves share an or-tree.
		s_nxt.rdata = 32'h0000_0000;
		if (rd_i) begin
			case (addr_i)
				`OFF_RX_PTR: s_nxt.rdata = s_r.ch[0].ptr;
				`OFF_RX_CNT: s_nxt.rdata = cnt_word(s_r.ch[0].cnt);
				`OFF_TX_PTR: s_nxt.rdata = s_r.ch[TXI].ptr;
				`OFF_TX_CNT: s_nxt.rdata = cnt_word(s_r.ch[TXI].cnt);
				`OFF_RX_NPTR: s_nxt.rdata = s_r.ch[0].nptr;
				`OFF_RX_NCNT: s_nxt.rdata = cnt_word(s_r.ch[0].ncnt);
				`OFF_TX_NPTR: s_nxt.rdata = s_r.ch[TXI].nptr;
				`OFF_TX_NCNT: s_nxt.rdata = cnt_word(s_r.ch[TXI].ncnt);
				`OFF_STATUS: begin
					s_nxt.rdata[`ST_BIT_RX_END] = s_r.rx_end;
					s_nxt.rdata[`ST_BIT_RX_FULL] = s_r.rx_full;
					s_nxt.rdata[`ST_BIT_TX_END] = s_r.tx_end;
					s_nxt.rdata[`ST_BIT_TX_EMPTY] = s_r.tx_empty;
					s_nxt.rdata[`ST_BIT_BUSY] =
						(s_r.st != periph_dma_pkg::ST_IDLE);
				end
				default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end
	end

	// State register; flags start set because the counters start at zero.
	// The reset branch assigns constants only.
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			for (int k = 0; k < 2; k++) begin
				s_r.ch[k].ptr <= `PTR_RST;
				s_r.ch[k].cnt <= `CNT_RST;
				s_r.ch[k].nptr <= `PTR_RST;
				s_r.ch[k].ncnt <= `CNT_RST;
			end
			s_r.rx_end <= `FLAG_RST;
			s_r.rx_full <= `FLAG_RST;
			s_r.tx_end <= `FLAG_RST;
			s_r.tx_empty <= `FLAG_RST;
			s_r.st <= periph_dma_pkg::ST_IDLE;
			s_r.unit <= `UNIT_BYTE;
			s_r.data <= 32'h0000_0000;
			s_r.rdata <= 32'h0000_0000;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Peripheral handshakes follow the state directly.
	// The take pulse is combinational so the peripheral can advance in
	// the same cycle; it must not feed rx_ready_i back combinationally.
	always_comb begin
		rx_take_o = (s_r.st == periph_dma_pkg::ST_IDLE) && rx_go;
		tx_write_o = (s_r.st == periph_dma_pkg::ST_TX_PUT);
		tx_data_o = s_r.data;
	end

	// Memory port; the address is read live so a rewrite is honoured.
	// A rewrite while the grant is pending moves the request with it.
	always_comb begin
		mem_req_o = (s_r.st == periph_dma_pkg::ST_RX_WR) ||
			(s_r.st == periph_dma_pkg::ST_TX_RD);
		mem_we_o = (s_r.st == periph_dma_pkg::ST_RX_WR);
		if (s_r.st == periph_dma_pkg::ST_RX_WR) begin
			mem_addr_o = s_r.ch[0].ptr;
		end else begin
			mem_addr_o = s_r.ch[TXI].ptr;
		end
		mem_wdata_o = s_r.data;
		mem_size_o = s_r.unit;
	end

	// Register read data and status flags.
	// All data outputs come straight from the state register.
	always_comb begin
		rd_data_o = s_r.rdata;
		rx_end_flag_o = s_r.rx_end;
		rx_buffers_full_flag_o = s_r.rx_full;
		tx_end_flag_o = s_r.tx_end;
		tx_buffers_empty_flag_o = s_r.tx_empty;
	end

endmodule

// file: logic/periph_dma_params.svh
// Constants of the peripheral DMA pointer and counter register set.
// Assumes byte addresses on a 12-bit register port and 32-bit data.
`ifndef PERIPH_DMA_PARAMS_SVH
`define PERIPH_DMA_PARAMS_SVH

// Register byte offsets.
`define OFF_RX_PTR 12'h100
`define OFF_RX_CNT 12'h104
`define OFF_TX_PTR 12'h108
`define OFF_TX_CNT 12'h10c
`define OFF_RX_NPTR 12'h110
`define OFF_RX_NCNT 12'h114
`define OFF_TX_NPTR 12'h118
`define OFF_TX_NCNT 12'h11c
`define OFF_STATUS 12'h128

// Field widths.
`define PTR_W 32
`define CNT_W 16

// Status register bit positions.
`define ST_BIT_RX_END 0
`define ST_BIT_RX_FULL 1
`define ST_BIT_TX_END 2
`define ST_BIT_TX_EMPTY 3
`define ST_BIT_BUSY 4

// Reset values.
`define PTR_RST 32'h0000_0000
`define CNT_RST 16'h0000
`define FLAG_RST 1'b1

// Transfer unit codes.
`define UNIT_BYTE 2'h0
`define UNIT_HALF 2'h1
`define UNIT_WORD 2'h2

`endif

// file: logic/periph_dma_pkg.sv
// Types shared by the peripheral DMA register set and its step logic.
// Assumes the constants header is on the include path.
`include "periph_dma_params.svh"

package periph_dma_pkg;

	// Transfer engine states.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX_WR,
		ST_TX_RD,
		ST_TX_WAIT,
		ST_TX_PUT
	} state_t;

	// One channel's current and following buffer descriptors.
	typedef struct packed {
		logic [`PTR_W-1:0] ptr;
		logic [`CNT_W-1:0] cnt;
		logic [`PTR_W-1:0] nptr;
		logic [`CNT_W-1:0] ncnt;
	} chan_t;

	// Pointer increment for one transfer unit.
	function automatic logic [`PTR_W-1:0] unit_bytes(input logic [1:0] unit);
		case (unit)
			`UNIT_BYTE: unit_bytes = 32'h0000_0001;
			`UNIT_HALF: unit_bytes = 32'h0000_0002;
			default: unit_bytes = 32'h0000_0004;
		endcase
	endfunction

endpackage

// file: logic/dma_channel_step.sv
// Next-value logic of one channel descriptor: step, software write, reload.
// Assumes the caller registers the result and gates step with a live count.
`timescale 1ns/1ps
`include "periph_dma_params.svh"

module dma_channel_step (
	// Present descriptor and transfer unit.
	input wire periph_dma_pkg::chan_t cur_i,
	input wire logic [1:0] unit_i,
	// Completion of one transfer.
	input wire logic step_i,
	// Software writes: bit0 ptr, bit1 cnt, bit2 nptr, bit3 ncnt.
	input wire logic [3:0] wr_sel_i,
	input wire logic [31:0] wdata_i,
	// Next descriptor and events.
	output periph_dma_pkg::chan_t nxt_o,
	output logic reached_zero_o,
	output logic both_zero_o
);

	// Step first, then software writes, so a write in the same cycle wins.
	always_comb begin
		periph_dma_pkg::chan_t c;
		logic zero_after_step;
		c = cur_i;
		zero_after_step = 1'b0;
		if (step_i) begin
			c.ptr = c.ptr + periph_dma_pkg::unit_bytes(unit_i);
			if (c.cnt != `CNT_RST) begin
				c.cnt = c.cnt - 16'h0001;
			end
			zero_after_step = (c.cnt == `CNT_RST);
		end
		if (wr_sel_i[0]) begin
			c.ptr = wdata_i;
		end
		if (wr_sel_i[1]) begin
			c.cnt = wdata_i[`CNT_W-1:0];
		end
		if (wr_sel_i[2]) begin
			c.nptr = wdata_i;
		end
		if (wr_sel_i[3]) begin
			c.ncnt = wdata_i[`CNT_W-1:0];
		end
		reached_zero_o = zero_after_step;
		both_zero_o = zero_after_step && (c.ncnt == `CNT_RST);
		// An empty current buffer with a live following one is chained in.
		if ((c.cnt == `CNT_RST) && (c.ncnt != `CNT_RST)) begin
			c.ptr = c.nptr;
			c.cnt = c.ncnt;
			c.nptr = `PTR_RST;
			c.ncnt = `CNT_RST;
		end
		nxt_o = c;
	end

endmodule

// file: bench/periph_dma_props_properties.sv
// Concurrent checks on the ports of the pointer and counter register set.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
`include "periph_dma_params.svh"

module periph_dma_props (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// Register port.
	input wire logic [11:0] addr_i,
	input wire logic [31:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rd_data_o,
	// Transfer side.
	input wire logic rx_enable_i,
	input wire logic rx_ready_i,
	input wire logic [31:0] rx_data_i,
	input wire logic rx_take_o,
	input wire logic tx_write_o,
	input wire logic mem_req_o,
	input wire logic mem_we_o,
	input wire logic [31:0] mem_wdata_o,
	input wire logic mem_gnt_i,
	input wire logic mem_rvalid_i,
	// Receive flags.
	input wire logic rx_end_flag_o,
	input wire logic rx_buffers_full_flag_o
);
	// All checks share the clock and are silenced during reset.
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	property p_rd_quiet;
		!rd_i |=> rd_data_o == 32'h0000_0000;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet)
		else $error("read data not quiet");
	property p_take_cause;
		rx_take_o |-> rx_enable_i && rx_ready_i;
	endproperty
	a_take_cause: assert property (p_take_cause)
		else $error("receive take without cause");
	property p_take_req;
		rx_take_o |=> mem_req_o && mem_we_o && mem_wdata_o == $past(rx_data_i);
	endproperty
	a_take_req: assert property (p_take_req)
		else $error("receive word not written");
	property p_wreq_cause;
		$rose(mem_req_o) && mem_we_o |-> $past(rx_take_o);
	endproperty
	a_wreq_cause: assert property (p_wreq_cause)
		else $error("memory write without take");
	property p_req_hold;
		mem_req_o && !mem_gnt_i |=> mem_req_o && $stable(mem_we_o);
	endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("request dropped before grant");
	property p_tx_write;
		tx_write_o |-> $past(mem_rvalid_i) ##1 !tx_write_o;
	endproperty
	a_tx_write: assert property (p_tx_write)
		else $error("transmit write mistimed");
	property p_rx_clear;
		wr_i && addr_i == `OFF_RX_CNT && wr_data_i[15:0] != 16'h0000 &&
			!(mem_req_o && mem_gnt_i) |=>
			!rx_end_flag_o && !rx_buffers_full_flag_o;
	endproperty
	a_rx_clear: assert property (p_rx_clear)
		else $error("receive flags not cleared");
	property p_full_end;
		rx_buffers_full_flag_o |-> rx_end_flag_o;
	endproperty
	a_full_end: assert property (p_full_end)
		else $error("full flag without end flag");
endmodule

bind periph_dma_ptr_counter_regs periph_dma_props u_props (.*);

// file: bench/dma_far_side.sv
// Behavioural peripheral and memory matrix facing the register set.
// Assumes the bench steers readiness and grant speed through its controls.
`timescale 1ns/1ps

module dma_far_side (
	// Clock, reset and bench controls.
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic rx_on_i,
	input wire logic tx_on_i,
	input wire logic slow_i,
	// Requests from the register set.
	input wire logic rx_take_o,
	input wire logic mem_req_o,
	input wire logic mem_we_o,
	input wire logic [31:0] mem_addr_o,
	// Answers to the register set.
	output logic rx_ready_i,
	output logic [31:0] rx_data_i,
	output logic tx_ready_i,
	output logic mem_gnt_i,
	output logic mem_rvalid_i,
	output logic [31:0] mem_rdata_i
);
	logic [31:0] rx_val;
	logic [31:0] rd_val;
	logic gnt_dly;

	// Data lines show the inverse when not valid, so a stale sample fails.
	assign rx_ready_i = rx_on_i;
	assign tx_ready_i = tx_on_i;
	assign rx_data_i = rx_ready_i ? rx_val : ~rx_val;
	assign mem_gnt_i = mem_req_o && (!slow_i || gnt_dly);
	assign mem_rdata_i = mem_rvalid_i ? rd_val : ~rd_val;

	// Receive words count up; a read answers one cycle after its grant.
	always @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			rx_val <= 32'h0000_00a0;
			rd_val <= 32'h0000_0000;
			gnt_dly <= 1'b0;
			mem_rvalid_i <= 1'b0;
		end else begin
			if (rx_take_o)
				rx_val <= rx_val + 32'h0000_0001;
			gnt_dly <= mem_req_o && !mem_gnt_i;
			mem_rvalid_i <= mem_gnt_i && !mem_we_o;
			if (mem_gnt_i && !mem_we_o)
				rd_val <= mem_addr_o ^ 32'h5a5a_0000;
		end
	end
endmodule

// file: bench/periph_dma_ptr_counter_regs_tb.sv
// Self-checking bench of the pointer and counter register set.
// Assumes the far-side model answers reads with address xor a pattern.
`timescale 1ns/1ps
`include "periph_dma_params.svh"

module periph_dma_ptr_counter_regs_tb;
	logic ref_clk_i, resetn_i, wr_i, rd_i, rx_enable_i, tx_enable_i;
	logic rx_ready_i, rx_take_o, tx_ready_i, tx_write_o, mem_req_o;
	logic mem_we_o, mem_gnt_i, mem_rvalid_i, rx_on_i, tx_on_i, slow_i;
	logic rx_end_flag_o, rx_buffers_full_flag_o;
	logic tx_end_flag_o, tx_buffers_empty_flag_o;
	logic [11:0] addr_i;
	logic [1:0] unit_i, mem_size_o;
	logic [31:0] wr_data_i, rd_data_o, rx_data_i, tx_data_o, mem_addr_o;
	logic [31:0] mem_wdata_o, mem_rdata_i;
	logic [31:0] waddr[$];
	logic [31:0] tdata[$];
	logic [1:0] wsize[$];
	logic [31:0] hd_rd_data;
	logic [31:0] flag_pins;
	int miscompares, total_checks;

	periph_dma_ptr_counter_regs #(.HALF_DUPLEX(1'b0)) uut (.*);
	dma_far_side far (.*);

	// Half duplex twin on the same register port; its transfer side idles.
	periph_dma_ptr_counter_regs #(.HALF_DUPLEX(1'b1)) uut_hd (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
		.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
		.rd_data_o(hd_rd_data), .rx_enable_i(1'b0), .tx_enable_i(1'b0),
		.unit_i(2'h0), .rx_ready_i(1'b0), .rx_data_i(32'h0000_0000),
		.rx_take_o(), .tx_ready_i(1'b0), .tx_write_o(), .tx_data_o(),
		.mem_req_o(), .mem_we_o(), .mem_addr_o(), .mem_wdata_o(),
		.mem_size_o(), .mem_gnt_i(1'b0), .mem_rvalid_i(1'b0),
		.mem_rdata_i(32'h0000_0000), .rx_end_flag_o(),
		.rx_buffers_full_flag_o(), .tx_end_flag_o(),
		.tx_buffers_empty_flag_o()
	);

	// Flag pins packed in status bit order.
	assign flag_pins = {28'h0, tx_buffers_empty_flag_o, tx_end_flag_o,
		rx_buffers_full_flag_o, rx_end_flag_o};

	// Free-running 100 MHz clock.
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	// Log every granted memory write and every word handed to the peripheral.
	always @(posedge ref_clk_i) begin
		if (mem_req_o && mem_gnt_i && mem_we_o) begin
			waddr.push_back(mem_addr_o);
			wsize.push_back(mem_size_o);
		end
		if (tx_write_o)
			tdata.push_back(tx_data_o);
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wr_data_i <= d;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe.
	task rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge ref_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 chk(rd_data_o, e);
	endtask

	// Same read, judged on the half duplex twin.
	task rd_hd(input logic [11:0] a, input logic [31:0] e);
		@(posedge ref_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 chk(hd_rd_data, e);
	endtask

	// Bounded wait for a number of logged transfers.
	task await_q(input int n, input bit tx);
		int i;
		i = 0;
		while ((tx ? tdata.size() : waddr.size()) < n) begin
			@(posedge ref_clk_i);
			i++;
			if (i > 500) begin
				miscompares++;
				$display("ERROR %0t timeout %h %h", $time, i, n);
				results();
			end
		end
		repeat (20) @(posedge ref_clk_i);
	endtask

	task t_reset;
		for (int a = 'h100; a <= 'h11c; a += 4)
			rd(a[11:0], 32'h0000_0000);
		rd(`OFF_STATUS, 32'h0000_000f);
		rd(12'h12c, 32'h0000_0000);
	endtask

	task t_regs;
		wr(`OFF_RX_CNT, 32'hffff_0003);
		wr(`OFF_TX_CNT, 32'h0000_0003);
		wr(`OFF_RX_NPTR, 32'h0000_2000);
		wr(`OFF_RX_NCNT, 32'hffff_1234);
		wr(`OFF_TX_NPTR, 32'h0000_3000);
		wr(`OFF_TX_NCNT, 32'hffff_1234);
		rd(`OFF_RX_CNT, 32'h0000_0003);
		rd(`OFF_RX_NPTR, 32'h0000_2000);
		rd(`OFF_RX_NCNT, 32'h0000_1234);
		rd(`OFF_TX_NPTR, 32'h0000_3000);
		rd(`OFF_TX_NCNT, 32'h0000_1234);
		rd(`OFF_STATUS, 32'h0000_0000);
	endtask

	// Byte receive that chains into a one-unit following buffer, then stops.
	task t_rx;
		wr(`OFF_RX_PTR, 32'h0000_1000);
		wr(`OFF_RX_NCNT, 32'h0000_0001);
		unit_i <= 2'h0;
		rx_enable_i <= 1'b1;
		await_q(4, 1'b0);
		rx_enable_i <= 1'b0;
		chk(32'(waddr.size()), 32'h0000_0004);
		for (int i = 0; i < 3; i++)
			chk(waddr[i], 32'h0000_1000 + i);
		chk(waddr[3], 32'h0000_2000);
		chk({30'h0, wsize[0]}, 32'h0000_0000);
		rd(`OFF_RX_PTR, 32'h0000_2001);
		rd(`OFF_RX_NPTR, 32'h0000_0000);
		rd(`OFF_RX_CNT, 32'h0000_0000);
		rd(`OFF_STATUS, 32'h0000_0003);
		chk(flag_pins, 32'h0000_0003);
	endtask

	// Word transmit with slow grants.
	task t_tx;
		wr(`OFF_TX_NCNT, 32'h0000_0000);
		wr(`OFF_TX_PTR, 32'h0000_0040);
		wr(`OFF_TX_CNT, 32'h0000_0002);
		unit_i <= 2'h2;
		slow_i <= 1'b1;
		tx_enable_i <= 1'b1;
		await_q(2, 1'b1);
		tx_enable_i <= 1'b0;
		chk(32'(tdata.size()), 32'h0000_0002);
		chk(tdata[0], 32'h0000_0040 ^ 32'h5a5a_0000);
		chk(tdata[1], 32'h0000_0044 ^ 32'h5a5a_0000);
		rd(`OFF_TX_PTR, 32'h0000_0048);
		rd(`OFF_STATUS, 32'h0000_000f);
		chk(flag_pins, 32'h0000_000f);
	endtask

	// Half-word receive with slow grants; the pointer steps by two.
	task t_hword;
		wr(`OFF_RX_PTR, 32'h0000_0800);
		wr(`OFF_RX_CNT, 32'h0000_0002);
		rd(`OFF_STATUS, 32'h0000_000c);
		unit_i <= 2'h1;
		rx_enable_i <= 1'b1;
		await_q(6, 1'b0);
		rx_enable_i <= 1'b0;
		chk(32'(waddr.size()), 32'h0000_0006);
		chk(waddr[4], 32'h0000_0800);
		chk(waddr[5], 32'h0000_0802);
		chk({30'h0, wsize[5]}, 32'h0000_0001);
		rd(`OFF_RX_PTR, 32'h0000_0804);
		rd(`OFF_STATUS, 32'h0000_000f);
		chk(flag_pins, 32'h0000_000f);
	endtask

	// Half duplex twin: each register pair reads back one shared storage.
	task t_half;
		wr(`OFF_RX_PTR, 32'h0000_0500);
		wr(`OFF_TX_CNT, 32'hffff_0007);
		wr(`OFF_TX_NPTR, 32'h0000_0600);
		wr(`OFF_RX_NCNT, 32'h0000_0009);
		rd_hd(`OFF_TX_PTR, 32'h0000_0500);
		rd_hd(`OFF_RX_CNT, 32'h0000_0007);
		rd_hd(`OFF_RX_NPTR, 32'h0000_0600);
		rd_hd(`OFF_TX_NCNT, 32'h0000_0009);
	endtask

	task results;
		if (miscompares == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Reset for 16 cycles, then run the scenarios in order.
	initial begin
		resetn_i = 1'b0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 12'h000;
		wr_data_i = 32'h0000_0000;
		rx_enable_i = 1'b0;
		tx_enable_i = 1'b0;
		unit_i = 2'h0;
		rx_on_i = 1'b1;
		tx_on_i = 1'b1;
		slow_i = 1'b0;
		miscompares = 0;
		total_checks = 0;
		repeat (16) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		t_reset();
		t_regs();
		t_rx();
		t_tx();
		t_hword();
		t_half();
		results();
	end
endmodule
